//--- include/pcx_defs.svh
/*
  Register indices, field positions, reset values and sizes of the port crossbar
  and low-port block. Assumes a 32-bit APB where register index n sits at byte 4*n.
*/
`ifndef PCX_DEFS_SVH
`define PCX_DEFS_SVH

`define PCX_NPIN 32
`define PCX_NSIG 28

`define PCX_IDX_PORT0 10'h080
`define PCX_IDX_PORT1 10'h090
`define PCX_IDX_PORT2 10'h0A0
`define PCX_IDX_P3FLAG 10'h0AD
`define PCX_IDX_PORT3 10'h0B0
`define PCX_IDX_P1MODE 10'h0BD
`define PCX_IDX_PUSHPULL 10'h0C0
`define PCX_IDX_IRQSTAT 10'h0C1
`define PCX_IDX_IRQMASK 10'h0C2
`define PCX_IDX_ROUTE_A 10'h0E1
`define PCX_IDX_ROUTE_B 10'h0E2
`define PCX_IDX_ROUTE_C 10'h0E3

`define PCX_LATCH_RST 8'hFF
`define PCX_P1MODE_RST 8'hFF
`define PCX_ROUTE_RST 8'h00
`define PCX_PUSHPULL_RST 32'h0000_0000

`define PCX_A_CMP0 7
`define PCX_A_CCLK 6
`define PCX_A_CAP_HI 5
`define PCX_A_CAP_LO 3
`define PCX_A_UART 2
`define PCX_A_SPI 1
`define PCX_A_SMB 0
`define PCX_C_PULLOFF 7
`define PCX_C_XBAR 6
`define PCX_C_T4EX 4
`define PCX_C_T4 3
`define PCX_C_UART 2
`define PCX_C_EXTMEM 1
`define PCX_C_CNV 0
`define PCX_ROUTE_C_MASK 8'hDF
`define PCX_F_PEND7 7
`define PCX_F_PEND6 6
`define PCX_F_POL7 3
`define PCX_F_POL6 2

`define PCX_PIN_ALE 5
`define PCX_PIN_RD 6
`define PCX_PIN_WR 7
`define PCX_PIN_P1 8
`define PCX_PIN_IRQ6 30
`define PCX_CAP_MAX 3'd5

`endif

//--- include/pcx_pkg.sv
/*
  Types of the port crossbar block. Assumes pcx_defs.svh for sizes.
*/
`include "pcx_defs.svh"
package pcx_pkg;
  typedef logic [`PCX_NPIN-1:0] pcx_pin_t;
  typedef logic [`PCX_NSIG-1:0] pcx_sig_t;
  typedef logic [5:0] pcx_slot_t;
  typedef pcx_slot_t [`PCX_NPIN-1:0] pcx_map_t;

  typedef struct packed {
    pcx_pin_t sync1;
    pcx_pin_t sync2;
    logic [1:0] edge_prev;
    pcx_pin_t latch;
    logic [7:0] p1_in_mode;
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [7:0] route_c;
    logic [1:0] edge_pend;
    logic [1:0] edge_pol;
    pcx_pin_t pushpull;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    pcx_pin_t pin_out;
    pcx_pin_t pin_oe_n;
    pcx_pin_t pullup_on;
    pcx_sig_t periph_in;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } pcx_state_s;
endpackage : pcx_pkg

//--- logic/pcx_top.sv
/*
  Port crossbar and low-port logic: routing registers, port latches, port 1 input
  mode, port 3 edge interrupts and pin drive for ports 0 to 3 (pins 0..31, P0.0 first).
  Assumes an APB master on mclk, peripherals and the external memory interface on
  mclk, and pins that arrive asynchronously.
*/
`include "pcx_defs.svh"
module pcx_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire pcx_pkg::pcx_pin_t pin_in,
  output pcx_pkg::pcx_pin_t pin_out,
  output pcx_pkg::pcx_pin_t pin_oe_n,
  output pcx_pkg::pcx_pin_t pullup_on,
  input wire pcx_pkg::pcx_sig_t periph_out,
  input wire pcx_pkg::pcx_sig_t periph_drive,
  output pcx_pkg::pcx_sig_t periph_in,
  input wire logic external_memory_iface_active,
  input wire logic external_memory_iface_mux_mode,
  input wire pcx_pkg::pcx_pin_t external_memory_iface_own,
  input wire pcx_pkg::pcx_pin_t external_memory_iface_drive,
  input wire pcx_pkg::pcx_pin_t external_memory_iface_out
);
  import pcx_pkg::*;

  // ---------------------------------------------------------------
  // Pin numbering
  // ---------------------------------------------------------------
  // Every pin vector in this block is 32 bits wide and covers ports 0 to 3.
  // Bit 0 is P0.0 and bit 31 is P3.7; port n occupies bits 8n+7 down to 8n.
  // Port 1 bits 15:8 are the only pins that can be put in analog mode.
  // Port 3 bits 31:30 feed the two edge interrupt detectors.
  // When external memory sits on the low ports, bits 7, 6 and 5 carry the
  // write strobe, the read strobe and, in multiplexed mode, the address latch.

  // ---------------------------------------------------------------
  // Peripheral signal order
  // ---------------------------------------------------------------
  // The index of a signal in periph_out, periph_drive and periph_in is also
  // its priority: the walk hands pins out in this order.
  //   0  first UART transmit          route_a bit 2
  //   1  first UART receive           route_a bit 2
  //   2  SPI clock                    route_a bit 1
  //   3  SPI data in                  route_a bit 1
  //   4  SPI data out                 route_a bit 1
  //   5  SPI slave select             route_a bit 1
  //   6  SMBus data                   route_a bit 0
  //   7  SMBus clock                  route_a bit 0
  //   8  second UART transmit         route_c bit 2
  //   9  second UART receive          route_c bit 2
  //   10 capture/compare output 0     route_a code 1 and up
  //   11 capture/compare output 1     route_a code 2 and up
  //   12 capture/compare output 2     route_a code 3 and up
  //   13 capture/compare output 3     route_a code 4 and up
  //   14 capture/compare output 4     route_a code 5
  //   15 counter array clock          route_a bit 6
  //   16 comparator 0 output          route_a bit 7
  //   17 comparator 1 output          route_b bit 0
  //   18 timer 0 input                route_b bit 1
  //   19 external interrupt 0         route_b bit 2
  //   20 timer 1 input                route_b bit 3
  //   21 external interrupt 1         route_b bit 4
  //   22 timer 2 input                route_b bit 5
  //   23 timer 2 external input       route_b bit 6
  //   24 timer 4 input                route_c bit 3
  //   25 timer 4 external input       route_c bit 4
  //   26 system clock output          route_b bit 7
  //   27 conversion start             route_c bit 0
  // Input signals leave their drive request low; a signal that has no pin
  // reads as one, which is the idle level of every low-active input here.

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // The bus index is paddr[11:2]; byte lanes are not decoded, so every
  // register is read and written as a whole word.
  //   0x080 port 0 latch, reads pin levels
  //   0x090 port 1 latch, reads pin levels, analog bits read zero
  //   0x0A0 port 2 latch, reads pin levels
  //   0x0AD port 3 edge flags: pending 7:6, polarity 3:2
  //   0x0B0 port 3 latch, reads pin levels
  //   0x0BD port 1 input mode, one is digital
  //   0x0C0 push-pull select, one bit per pin
  //   0x0C1 interrupt status, write one to clear
  //   0x0C2 interrupt mask
  //   0x0E1 route_ctrl_a
  //   0x0E2 route_ctrl_b
  //   0x0E3 route_ctrl_c, bit 5 reads zero
  // Any other index answers with an error and ignores a write.

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Pins pass two synchroniser stages before any logic sees them, so a pin
  // change reaches a register read and periph_in both three edges later.
  // A register write shows on the pins one edge after the write edge,
  // because every output comes from the state register.
  // The pending flags and the interrupt status are set one edge after the
  // synchronised edge; the interrupt line follows on the same edge.
  // A set and a clear in the same cycle leave the flag set, so an edge that
  // arrives while software clears the previous one is never lost.

  // ---------------------------------------------------------------
  // Ownership of a pin, highest first
  // ---------------------------------------------------------------
  // 1. Crossbar off: the pin is an input with its pull-up as configured.
  // 2. External data move on a pin the memory interface owns: its value and
  //    drive, whatever the crossbar and the latch hold.
  // 3. A peripheral signal assigned by the walk: its value and drive, with
  //    open-drain or push-pull as for the latch.
  // 4. The port latch: a zero drives low, a one drives high in push-pull
  //    and floats in open-drain.
  // The pull-up is off on a pin that drives low, on an analog pin, and on
  // every pin while the global pull-up off bit is set.

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [9:0] idx);
    case (idx)
      `PCX_IDX_PORT0, `PCX_IDX_PORT1, `PCX_IDX_PORT2, `PCX_IDX_PORT3,
      `PCX_IDX_P3FLAG, `PCX_IDX_P1MODE, `PCX_IDX_PUSHPULL, `PCX_IDX_IRQSTAT,
      `PCX_IDX_IRQMASK, `PCX_IDX_ROUTE_A, `PCX_IDX_ROUTE_B,
      `PCX_IDX_ROUTE_C: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  // Walks the pins from P0.0 upward and hands each non-skipped pin to the next
  // enabled signal. A purely combinational walk keeps the map consistent with
  // the registers in the same cycle; the cost is a long chain of 32 pin steps of 28 signal checks each.
  function automatic pcx_map_t xbar_map(input pcx_sig_t en, input pcx_pin_t skip);
    pcx_map_t m;
    logic [5:0] cur;
    m = '0;
    cur = 6'h00;
    for (int p = 0; p < `PCX_NPIN; p++) begin
      for (int k = 0; k < `PCX_NSIG; k++) begin
        if (cur < 6'(`PCX_NSIG)) begin
          if (!en[cur[4:0]]) begin
            cur = cur + 6'h01;
          end
        end
      end
      if (!skip[p] && cur < 6'(`PCX_NSIG)) begin
        m[p] = {1'b1, cur[4:0]};
        cur = cur + 6'h01;
      end
    end
    xbar_map = m;
  endfunction : xbar_map

  pcx_state_s st;
  pcx_state_s next_st;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [9:0] idx;
    logic wr;
    logic [31:0] rd;
    pcx_sig_t en;
    pcx_pin_t skip;
    pcx_pin_t analog;
    pcx_pin_t dig;
    pcx_map_t map;
    logic [1:0] ev;
    logic [1:0] flag_clr;
    logic [1:0] stat_clr;
    logic val;
    logic drv;
    logic [4:0] s;
    idx = paddr[11:2];
    wr = psel && penable && st.pready && pwrite && reg_hit(idx);
    rd = 32'h0000_0000;
    en = '0;
    skip = '0;
    analog = '0;
    map = '0;
    flag_clr = 2'b00;
    stat_clr = 2'b00;
    val = 1'b1;
    drv = 1'b0;
    s = 5'h00;
    next_st = st;

    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.edge_prev = st.sync2[`PCX_PIN_IRQ6 +: 2];

    // Analog port 1 pins lose their digital input path and read as zero.
    analog[`PCX_PIN_P1 +: 8] = ~st.p1_in_mode;
    dig = st.sync2 & ~analog;

    // Register writes.
    if (wr) begin
      case (idx)
        `PCX_IDX_PORT0: next_st.latch[7:0] = pwdata[7:0];
        `PCX_IDX_PORT1: next_st.latch[15:8] = pwdata[7:0];
        `PCX_IDX_PORT2: next_st.latch[23:16] = pwdata[7:0];
        `PCX_IDX_PORT3: next_st.latch[31:24] = pwdata[7:0];
        `PCX_IDX_P1MODE: next_st.p1_in_mode = pwdata[7:0];
        `PCX_IDX_ROUTE_A: next_st.route_a = pwdata[7:0];
        `PCX_IDX_ROUTE_B: next_st.route_b = pwdata[7:0];
        `PCX_IDX_ROUTE_C: next_st.route_c = pwdata[7:0] & `PCX_ROUTE_C_MASK;
        `PCX_IDX_PUSHPULL: next_st.pushpull = pwdata;
        `PCX_IDX_IRQMASK: next_st.irq_mask = pwdata[1:0];
        `PCX_IDX_IRQSTAT: stat_clr = pwdata[1:0];
        `PCX_IDX_P3FLAG: begin
          // Pending flags clear on a written zero; a written one leaves them.
          flag_clr = ~{pwdata[`PCX_F_PEND7], pwdata[`PCX_F_PEND6]};
          next_st.edge_pol = {pwdata[`PCX_F_POL7], pwdata[`PCX_F_POL6]};
        end
        default: next_st.latch = st.latch;
      endcase
    end

    // Edge interrupts on P3.6 and P3.7; a new edge wins over a clear.
    for (int i = 0; i < 2; i++) begin
      ev[i] = st.edge_pol[i] ? (st.sync2[`PCX_PIN_IRQ6 + i] && !st.edge_prev[i])
                             : (!st.sync2[`PCX_PIN_IRQ6 + i] && st.edge_prev[i]);
    end
    next_st.edge_pend = (st.edge_pend & ~flag_clr) | ev;
    next_st.irq_status = (st.irq_status & ~stat_clr) | ev;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // Signal enables in priority order.
    en[1:0] = {2{st.route_a[`PCX_A_UART]}};
    en[5:2] = {4{st.route_a[`PCX_A_SPI]}};
    en[7:6] = {2{st.route_a[`PCX_A_SMB]}};
    en[9:8] = {2{st.route_c[`PCX_C_UART]}};
    for (int i = 0; i < 5; i++) begin
      // Reserved codes above five route nothing.
      en[10 + i] = (st.route_a[`PCX_A_CAP_HI:`PCX_A_CAP_LO] <= `PCX_CAP_MAX) &&
                   (3'(i) < st.route_a[`PCX_A_CAP_HI:`PCX_A_CAP_LO]);
    end
    en[15] = st.route_a[`PCX_A_CCLK];
    en[16] = st.route_a[`PCX_A_CMP0];
    en[17] = st.route_b[0];
    en[22:18] = st.route_b[5:1];
    en[23] = st.route_b[6];
    en[24] = st.route_c[`PCX_C_T4];
    en[25] = st.route_c[`PCX_C_T4EX];
    en[26] = st.route_b[7];
    en[27] = st.route_c[`PCX_C_CNV];

    skip = analog;
    if (st.route_c[`PCX_C_EXTMEM]) begin
      skip[`PCX_PIN_WR] = 1'b1;
      skip[`PCX_PIN_RD] = 1'b1;
      skip[`PCX_PIN_ALE] = external_memory_iface_mux_mode;
    end
    map = xbar_map(en, skip);

    // Pin drive.
    next_st.periph_in = '1;
    for (int p = 0; p < `PCX_NPIN; p++) begin
      s = map[p][4:0];
      if (!st.route_c[`PCX_C_XBAR]) begin
        val = 1'b1;
        drv = 1'b0;
      end else if (external_memory_iface_active && external_memory_iface_own[p]) begin
        val = external_memory_iface_out[p];
        drv = external_memory_iface_drive[p];
      end else if (map[p][5]) begin
        val = periph_out[s];
        drv = periph_drive[s] && (!val || st.pushpull[p]);
        next_st.periph_in[s] = dig[p];
      end else begin
        val = st.latch[p];
        drv = !val || st.pushpull[p];
      end
      next_st.pin_out[p] = val;
      next_st.pin_oe_n[p] = !drv;
      next_st.pullup_on[p] = !st.route_c[`PCX_C_PULLOFF] && !(drv && !val) &&
                             !analog[p];
    end

    // Register reads, sampled in the setup cycle.
    case (idx)
      `PCX_IDX_PORT0: rd[7:0] = dig[7:0];
      `PCX_IDX_PORT1: rd[7:0] = dig[15:8];
      `PCX_IDX_PORT2: rd[7:0] = dig[23:16];
      `PCX_IDX_PORT3: rd[7:0] = dig[31:24];
      `PCX_IDX_P1MODE: rd[7:0] = st.p1_in_mode;
      `PCX_IDX_ROUTE_A: rd[7:0] = st.route_a;
      `PCX_IDX_ROUTE_B: rd[7:0] = st.route_b;
      `PCX_IDX_ROUTE_C: rd[7:0] = st.route_c;
      `PCX_IDX_PUSHPULL: rd = st.pushpull;
      `PCX_IDX_IRQSTAT: rd[1:0] = st.irq_status;
      `PCX_IDX_IRQMASK: rd[1:0] = st.irq_mask;
      `PCX_IDX_P3FLAG: begin
        rd[`PCX_F_PEND7] = st.edge_pend[1];
        rd[`PCX_F_PEND6] = st.edge_pend[0];
        rd[`PCX_F_POL7] = st.edge_pol[1];
        rd[`PCX_F_POL6] = st.edge_pol[0];
      end
      default: rd = 32'h0000_0000;
    endcase

    // Zero-wait slave: ready is raised for the access cycle that follows setup.
    next_st.pready = psel && !penable;
    next_st.pslverr = psel && !penable && !reg_hit(idx);
    if (psel && !penable) begin
      next_st.prdata = (reg_hit(idx) && !pwrite) ? rd : 32'h0000_0000;
    end

    if (!nrst) begin
      next_st = '0;
      next_st.sync1 = '1;
      next_st.sync2 = '1;
      next_st.edge_prev = 2'b11;
      next_st.latch = {4{`PCX_LATCH_RST}};
      next_st.p1_in_mode = `PCX_P1MODE_RST;
      next_st.route_a = `PCX_ROUTE_RST;
      next_st.route_b = `PCX_ROUTE_RST;
      next_st.route_c = `PCX_ROUTE_RST;
      next_st.pushpull = `PCX_PUSHPULL_RST;
      next_st.pin_out = '1;
      next_st.pin_oe_n = '1;
      next_st.pullup_on = '1;
      next_st.periph_in = '1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign pullup_on = st.pullup_on;
  assign periph_in = st.periph_in;
endmodule : pcx_top

//--- test/pcx_chk.sv
/*
  Checker of the bus handshake, reset and pull-up relations at the ports of pcx_top.
  Assumes one clock mclk and a synchronous active-low reset nrst.
*/
`include "pcx_defs.svh"
module pcx_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire pcx_pkg::pcx_pin_t pin_out,
  input wire pcx_pkg::pcx_pin_t pin_oe_n,
  input wire pcx_pkg::pcx_pin_t pullup_on,
  input wire pcx_pkg::pcx_sig_t periph_in
);
  import pcx_pkg::*;
  logic mapped;
  logic [9:0] idx;
  assign idx = paddr[11:2];
  assign mapped = idx inside {`PCX_IDX_PORT0, `PCX_IDX_PORT1, `PCX_IDX_PORT2,
    `PCX_IDX_P3FLAG, `PCX_IDX_PORT3, `PCX_IDX_P1MODE, `PCX_IDX_PUSHPULL,
    `PCX_IDX_IRQSTAT, `PCX_IDX_IRQMASK, `PCX_IDX_ROUTE_A, `PCX_IDX_ROUTE_B,
    `PCX_IDX_ROUTE_C};
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_ready_next: assert property (@(posedge mclk) disable iff (!nrst)
    s_setup |=> s_answer) else $error("pready not one cycle after setup");
  chk_ready_cause: assert property (@(posedge mclk) disable iff (!nrst)
    !psel |=> !pready) else $error("pready without a setup");
  chk_err_only: assert property (@(posedge mclk) disable iff (!nrst)
    pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  chk_err_cause: assert property (@(posedge mclk) disable iff (!nrst)
    pready |-> pslverr == !mapped) else $error("pslverr disagrees with map");
  chk_unused_zero: assert property (@(posedge mclk) disable iff (!nrst)
    pready && idx == `PCX_IDX_P3FLAG |-> prdata[5:4] == 2'h0 && prdata[1:0] == 2'h0)
    else $error("unused flag bits read non-zero");
  chk_reset_pins: assert property (@(posedge mclk)
    !nrst |=> &pin_oe_n && &pin_out) else $error("pins not released by reset");
  chk_reset_bus: assert property (@(posedge mclk)
    !nrst |=> !pready && !irq && &periph_in && &pullup_on)
    else $error("outputs not at reset values");
  chk_pull_low: assert property (@(posedge mclk) disable iff (!nrst)
    (~pin_oe_n & ~pin_out & pullup_on) == '0) else $error("pull-up on a low pin");
endmodule : pcx_chk
bind pcx_top pcx_chk u_chk (.mclk, .nrst, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .irq, .pin_out, .pin_oe_n, .pullup_on, .periph_in);

//--- test/pcx_pad_model.sv
/*
  Model of the pads and the outside world on pins P0.0 to P3.7.
  Assumes the bench gives an external drive enable and value per pin.
*/
`include "pcx_defs.svh"
module pcx_pad_model (
  input wire logic mclk,
  input wire pcx_pkg::pcx_pin_t pin_out,
  input wire pcx_pkg::pcx_pin_t pin_oe_n,
  input wire pcx_pkg::pcx_pin_t pullup_on,
  input wire pcx_pkg::pcx_pin_t ext_en,
  input wire pcx_pkg::pcx_pin_t ext_val,
  output pcx_pkg::pcx_pin_t pin_in
);
  import pcx_pkg::*;
  pcx_pin_t last;
  always_ff @(posedge mclk) begin
    last <= pin_in;
  end
  // A floating pin shows the inverse of its last level, so a stale value never passes.
  always_comb begin
    for (int i = 0; i < `PCX_NPIN; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last[i];
    end
  end
endmodule : pcx_pad_model

//--- test/testbench.sv
/*
  Self-checking bench of pcx_top over APB with a pad model on the pins.
  Assumes the memory interface stays idle for the whole run.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pcx_pkg::*;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  pcx_pin_t pin_in, pin_out, pin_oe_n, pullup_on, ext_en, ext_val;
  pcx_sig_t periph_out, periph_drive, periph_in;
  int failures, cmp_count;
  int cyc = 0;
  localparam logic [11:0] a_p0 = 12'h200, a_flg = 12'h2B4, a_p1m = 12'h2F4;
  localparam logic [11:0] a_pp = 12'h300, a_st = 12'h304, a_mk = 12'h308;
  localparam logic [11:0] a_ra = 12'h384, a_rb = 12'h388, a_rc = 12'h38C;
  pcx_top u_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .pin_in, .pin_out, .pin_oe_n, .pullup_on, .periph_out,
    .periph_drive, .periph_in, .external_memory_iface_active(1'b0), .external_memory_iface_mux_mode(1'b0),
    .external_memory_iface_own('0), .external_memory_iface_drive('0), .external_memory_iface_out('0));
  pcx_pad_model u_pad (.mclk, .pin_out, .pin_oe_n, .pullup_on, .ext_en, .ext_val,
    .pin_in);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] x;
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_en, ext_val, periph_out, periph_drive, failures, cmp_count} = '0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(a_ra, 32'h0);
    rd(a_rb, 32'h0);
    rd(a_rc, 32'h0);
    rd(a_p1m, 32'hFF);
    rd(a_flg, 32'h0);
    rd(a_p0, 32'hFF);
    apb(1'b0, 12'h004, 32'h0);
    chk(e, 1'b1);
    wr(a_rc, 32'h20);
    rd(a_rc, 32'h0);
    $display("registers done");
    wr(a_p0, 32'h0);
    repeat (4) @(posedge mclk);
    chk(pin_oe_n, 32'hFFFF_FFFF);
    wr(a_rc, 32'h40);
    repeat (4) @(posedge mclk);
    chk({pin_oe_n[7:0], pin_out[7:0], pullup_on[7:0]}, 32'h0);
    rd(a_p0, 32'h0);
    ext_en <= 32'h2;
    wr(a_p0, 32'h0F);
    repeat (4) @(posedge mclk);
    rd(a_p0, 32'h0D);
    wr(a_pp, 32'h1);
    repeat (4) @(posedge mclk);
    chk({pin_oe_n[0], pin_out[0]}, 2'b01);
    $display("latches done");
    wr(a_p0, 32'hFF);
    // UART transmit and all five capture/compare outputs request drive.
    periph_drive <= 28'h7C01;
    for (int c = 0; c < 8; c++) begin
      wr(a_ra, 32'h04 | (c << 3));
      repeat (4) @(posedge mclk);
      n = (c < 6) ? c : 0;
      x = ~(8'h01 | (((8'h01 << n) - 8'h01) << 2));
      chk({pin_oe_n[7:0], pin_out[0], periph_in[1]}, {x, 2'b00});
    end
    ext_en <= '0;
    repeat (4) @(posedge mclk);
    chk(periph_in[1], 1'b1);
    $display("routing done");
    wr(a_mk, 32'h3);
    ext_en <= 32'h4000_0000;
    repeat (5) @(posedge mclk);
    rd(a_flg, 32'h40);
    rd(a_st, 32'h1);
    chk(irq, 1'b1);
    wr(a_st, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    wr(a_flg, 32'h08);
    rd(a_flg, 32'h08);
    ext_en <= 32'hC000_0000;
    repeat (5) @(posedge mclk);
    rd(a_flg, 32'h08);
    wr(a_mk, 32'h1);
    ext_en <= 32'h4000_0000;
    repeat (5) @(posedge mclk);
    rd(a_flg, 32'h88);
    rd(a_st, 32'h2);
    chk(irq, 1'b0);
    $display("edge interrupts done");
    report_and_stop();
  end
endmodule : testbench
